// File: shared/ssp_pkg.sv
// How it works
// - In a write cycle with buffer room, data and parity pins are captured into a two-entry write buffer on the rising system clock.
// - Read data for the address sampled at one edge is driven after the next edge.
// - With the output gate low, data and parity pins are driven for a read word that is due, unless a write is on the pins that cycle.
// - With the output gate high, data and parity pins are released.
// - A grounded burst-order strap selects linear order.
// - A high or floating burst-order strap selects interleaved order.
// - The test serial output moves to its next bit on the test clock's falling edge.
// - Test data and mode inputs are sampled on the test clock's rising edge.
// - A two-bit wrapping counter cleared on load, added to or XORed with the two lowest address bits, makes the burst.
package ssp_pkg;

  localparam int ADDR_W    = 19;
  localparam int DATA_W    = 32;
  localparam int PAR_W     = 4;
  localparam int BURST_W   = 2;
  localparam int SYNC_W    = 2;

  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;

  // One word on the data port, payload and parity
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [PAR_W-1:0]  parity;
  } ssp_word_t;

  // One captured write, bound for the core
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    ssp_word_t         word;
  } ssp_wr_t;

  localparam ssp_word_t WORD_RESET = '0;
  localparam ssp_wr_t   WR_RESET   = '0;

  // Whole state of the port block
  typedef struct packed {
    logic [SYNC_W-1:0]  modeSync;
    logic               modeLinear;
    logic [SYNC_W-1:0]  oeSync;
    logic [SYNC_W:0]    tckSync;
    logic [SYNC_W-1:0]  tdiSync;
    logic [SYNC_W-1:0]  tmsSync;
    logic               tdiBit;
    logic               tmsBit;
    logic               tdo;
    logic [ADDR_W-3:0]  addrHigh;
    logic [BURST_W-1:0] start;
    logic [BURST_W-1:0] count;
    logic [ADDR_W-1:0]  memAddr;
    logic               readPend;
    ssp_word_t          outWord;
    logic               dqOe_n;
    ssp_wr_t            e0;
    ssp_wr_t            e1;
    logic               v0;
    logic               v1;
    logic               bufFree;
  } ssp_state_t;

endpackage : ssp_pkg

// File: verilog/ssp_data_port.sv
module ssp_data_port (
  input  wire logic                      ref_clk,
  input  wire logic                      rst_n,
  input  wire logic [ssp_pkg::ADDR_W-1:0] addrIn,
  input  wire logic                      addrLoad,
  input  wire logic                      burstAdvance,
  input  wire logic                      readCycle,
  input  wire logic                      writeCycle,
  input  wire logic                      modeStrap,
  input  wire logic                      outEnable_n,
  input  wire ssp_pkg::ssp_word_t        dqIn,
  output ssp_pkg::ssp_word_t             dqOut,
  output logic                           dqOe_n,
  output logic      [ssp_pkg::ADDR_W-1:0] memAddr,
  input  wire ssp_pkg::ssp_word_t        rdData,
  output logic                           wrValid,
  output ssp_pkg::ssp_wr_t               wrItem,
  input  wire logic                      wrReady,
  output logic                           wrSpace,
  input  wire logic                      tck,
  input  wire logic                      tdi,
  input  wire logic                      tms,
  output logic                           tdo,
  output logic                           tdiBit,
  output logic                           tmsBit
);

  ssp_pkg::ssp_state_t s;
  ssp_pkg::ssp_state_t next_s;
  logic                tckRise;
  logic                tckFall;
  logic                pop;
  logic                push;
  ssp_pkg::ssp_wr_t    item;

  // Burst address low bits from start value and advance count
  function automatic logic [ssp_pkg::BURST_W-1:0] burstLow(
    input logic [ssp_pkg::BURST_W-1:0] start,
    input logic [ssp_pkg::BURST_W-1:0] count,
    input logic                        linear
  );
    if (linear)
    begin
      return ssp_pkg::BURST_W'(start + count);
    end
    return start ^ count;
  endfunction : burstLow

  // Edges of the synchronised test clock
  assign tckRise = s.tckSync[1] & ~s.tckSync[2];
  assign tckFall = ~s.tckSync[1] & s.tckSync[2];
  assign pop     = s.v0 & wrReady;
  assign push    = writeCycle & (~s.v1 | pop);
  assign item    = '{addr: s.memAddr, word: dqIn};

  // Next state of the whole block
  always_comb
  begin
    next_s = s;
    next_s.modeSync = {s.modeSync[0], modeStrap};
    next_s.oeSync   = {s.oeSync[0], outEnable_n};
    next_s.tckSync  = {s.tckSync[1:0], tck};
    next_s.tdiSync  = {s.tdiSync[0], tdi};
    next_s.tmsSync  = {s.tmsSync[0], tms};
    // Test port sampling and shifting
    if (tckRise)
    begin
      next_s.tdiBit = s.tdiSync[1];
      next_s.tmsBit = s.tmsSync[1];
    end
    if (tckFall)
    begin
      next_s.tdo = s.tdiBit;
    end
    // Burst counter
    if (addrLoad)
    begin
      next_s.addrHigh = addrIn[ssp_pkg::ADDR_W-1:ssp_pkg::BURST_W];
      next_s.start    = addrIn[ssp_pkg::BURST_W-1:0];
      next_s.count    = ssp_pkg::BURST_ZERO;
    end
    else if (burstAdvance)
    begin
      next_s.count = ssp_pkg::BURST_W'(s.count + ssp_pkg::BURST_ONE);
    end
    next_s.memAddr = {next_s.addrHigh,
                      burstLow(next_s.start, next_s.count, s.modeLinear)};
    // Read pipeline and output drive
    next_s.readPend = readCycle;
    if (s.readPend)
    begin
      next_s.outWord = rdData;
    end
    next_s.dqOe_n = ~(s.readPend & ~s.oeSync[1] & ~writeCycle);
    // Two-entry write buffer, captured from the pins
    if (pop)
    begin
      next_s.e0 = s.e1;
      next_s.v0 = s.v1;
      next_s.v1 = 1'b0;
    end
    if (push)
    begin
      if (!next_s.v0)
      begin
        next_s.e0 = item;
        next_s.v0 = 1'b1;
      end
      else
      begin
        next_s.e1 = item;
        next_s.v1 = 1'b1;
      end
    end
    next_s.bufFree = ~next_s.v1;
    // Reset; the strap is caught while reset is held
    if (!rst_n)
    begin
      next_s.modeLinear = ~s.modeSync[1];
      next_s.tdiBit     = 1'b0;
      next_s.tmsBit     = 1'b0;
      next_s.tdo        = 1'b0;
      next_s.addrHigh   = '0;
      next_s.start      = ssp_pkg::BURST_ZERO;
      next_s.count      = ssp_pkg::BURST_ZERO;
      next_s.memAddr    = '0;
      next_s.readPend   = 1'b0;
      next_s.outWord    = ssp_pkg::WORD_RESET;
      next_s.dqOe_n     = 1'b1;
      next_s.e0         = ssp_pkg::WR_RESET;
      next_s.e1         = ssp_pkg::WR_RESET;
      next_s.v0         = 1'b0;
      next_s.v1         = 1'b0;
      next_s.bufFree    = 1'b1;
    end
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    s <= next_s;
  end

  // Outputs straight from state
  assign dqOut   = s.outWord;
  assign dqOe_n  = s.dqOe_n;
  assign memAddr = s.memAddr;
  assign wrValid = s.v0;
  assign wrItem  = s.e0;
  assign wrSpace = s.bufFree;
  assign tdo     = s.tdo;
  assign tdiBit  = s.tdiBit;
  assign tmsBit  = s.tmsBit;

  // Captured write word reaches the buffer head
  property p_capture;
    @(posedge ref_clk) disable iff (!rst_n)
    (writeCycle && !s.v0) |=> (wrValid && wrItem.word == $past(dqIn));
  endproperty
  a_capture: assert property (p_capture)
    else $error("write word not captured");

  // Read data appears two edges after the read request
  property p_read_latency;
    @(posedge ref_clk) disable iff (!rst_n)
    readCycle |-> ##2 (dqOut == $past(rdData));
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("read data latency wrong");

  // Drive when gate low and a read word is due
  property p_drive;
    @(posedge ref_clk) disable iff (!rst_n)
    (s.readPend && !s.oeSync[1] && !writeCycle) |=> !dqOe_n;
  endproperty
  a_drive: assert property (p_drive)
    else $error("data pins not driven");

  // Release when gate high
  property p_release;
    @(posedge ref_clk) disable iff (!rst_n)
    s.oeSync[1] |=> dqOe_n;
  endproperty
  a_release: assert property (p_release)
    else $error("data pins not released");

  // Burst advance steps
  sequence s_advance;
    burstAdvance && !addrLoad;
  endsequence

  property p_linear;
    @(posedge ref_clk) disable iff (!rst_n)
    (s_advance and s.modeLinear) |=>
      memAddr[1:0] == 2'($past(memAddr[1:0]) + 2'h1);
  endproperty
  a_linear: assert property (p_linear)
    else $error("linear burst step wrong");

  property p_interleave;
    @(posedge ref_clk) disable iff (!rst_n)
    (s_advance and !s.modeLinear) |=>
      memAddr[1:0] == ($past(s.start) ^ 2'($past(s.count) + 2'h1));
  endproperty
  a_interleave: assert property (p_interleave)
    else $error("interleaved burst step wrong");

  property p_load;
    @(posedge ref_clk) disable iff (!rst_n)
    addrLoad |=> memAddr == $past(addrIn);
  endproperty
  a_load: assert property (p_load)
    else $error("burst load wrong");

  property p_wrap;
    @(posedge ref_clk) disable iff (!rst_n)
    (addrLoad ##1 s_advance [*4]) |=>
      memAddr[1:0] == s.start;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("burst does not wrap");

  property p_tdo;
    @(posedge ref_clk) disable iff (!rst_n)
    tckFall |=> tdo == $past(s.tdiBit);
  endproperty
  a_tdo: assert property (p_tdo)
    else $error("serial out not updated on fall");

  property p_tdo_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    !tckFall |=> $stable(tdo);
  endproperty
  a_tdo_hold: assert property (p_tdo_hold)
    else $error("serial out moved off fall");

  property p_sample;
    @(posedge ref_clk) disable iff (!rst_n)
    tckRise |=> (tdiBit == $past(s.tdiSync[1]) &&
                 tmsBit == $past(s.tmsSync[1]));
  endproperty
  a_sample: assert property (p_sample)
    else $error("test inputs not sampled on rise");

endmodule : ssp_data_port

// File: testbench/ssp_core_model.sv
module ssp_core_model (
  input  wire logic                       ref_clk,
  input  wire logic [ssp_pkg::ADDR_W-1:0] memAddr,
  output ssp_pkg::ssp_word_t              rdData,
  input  wire logic                       stall,
  output logic                            wrReady
);
  timeunit 1ns;
  timeprecision 100ps;
  // Core read word is a fixed pattern of the address
  always_comb rdData = {13'h0, memAddr, memAddr[3:0]};
  // Core takes the buffer head only while not stalled
  always_comb wrReady = !stall;
endmodule : ssp_core_model

// File: testbench/ssp_data_port_tb_top.sv
module ssp_data_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                       ref_clk, rst_n, addrLoad, burstAdvance;
  logic                       readCycle, writeCycle, modeStrap, outEnable_n;
  logic [ssp_pkg::ADDR_W-1:0] addrIn, memAddr, a;
  ssp_pkg::ssp_word_t         dqIn, dqOut, rdData;
  ssp_pkg::ssp_wr_t           wrItem;
  ssp_pkg::ssp_wr_t           expQ[$];
  logic                       dqOe_n, wrValid, wrReady, wrSpace, stall;
  logic                       tck, tdi, tms, tdo, tdiBit, tmsBit;
  logic [1:0]                 low;
  int                         nErrors, checks, seed;
  ssp_data_port u_ssp_data_port (.ref_clk(ref_clk), .rst_n(rst_n),
    .addrIn(addrIn), .addrLoad(addrLoad), .burstAdvance(burstAdvance),
    .readCycle(readCycle), .writeCycle(writeCycle), .modeStrap(modeStrap),
    .outEnable_n(outEnable_n), .dqIn(dqIn), .dqOut(dqOut), .dqOe_n(dqOe_n),
    .memAddr(memAddr), .rdData(rdData), .wrValid(wrValid), .wrItem(wrItem),
    .wrReady(wrReady), .wrSpace(wrSpace), .tck(tck), .tdi(tdi), .tms(tms),
    .tdo(tdo), .tdiBit(tdiBit), .tmsBit(tmsBit));
  ssp_core_model u_ssp_core_model (.ref_clk(ref_clk), .memAddr(memAddr),
    .rdData(rdData), .stall(stall), .wrReady(wrReady));
  // Compare one value and count it
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  // Print the verdict and stop
  task automatic give_verdict;
    if (nErrors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // Inputs move a fixed delay after the rising edge
  task automatic step;
    @(posedge ref_clk);
    #2;
  endtask : step
  // Reset with the strap held static throughout
  task automatic do_reset(input logic m);
    rst_n = 1'b0;
    modeStrap = m;
    repeat (10) step();
    rst_n = 1'b1;
    check({dqOe_n, wrValid, wrSpace}, 3'h5);
  endtask : do_reset
  // Clock source
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Scoreboard: a head that the next edge accepts must match the oldest note
  always @(negedge ref_clk)
    if (rst_n === 1'b1 && wrValid === 1'b1 && wrReady === 1'b1)
    begin
      if (expQ.size() == 0)
        check(64'h1, 64'h0);
      else
        check(wrItem, expQ.pop_front());
    end
  // Watchdog
  initial
  begin
    #(20000 * 25);
    nErrors++;
    give_verdict();
  end
  // Main sequence
  initial
  begin
    seed = 32'h0ffb7015;
    {rst_n, addrLoad, burstAdvance, readCycle, writeCycle} = '0;
    {modeStrap, outEnable_n, tck, tdi, tms, stall} = 6'h02;
    addrIn = '0;
    dqIn = '0;
    for (int m = 0; m < 2; m++)
    begin
      do_reset(m[0]);
      // Every start value, four advances and one wrap
      for (int s = 0; s < 4; s++)
      begin
        addrIn = {17'($random(seed)), s[1:0]};
        addrLoad = 1'b1;
        burstAdvance = m[0];
        step();
        addrLoad = 1'b0;
        burstAdvance = 1'b1;
        for (int k = 0; k < 5; k++)
        begin
          low = m[0] ? (s[1:0] ^ k[1:0]) : (s[1:0] + k[1:0]);
          check(memAddr, {addrIn[18:2], low});
          step();
        end
        burstAdvance = 1'b0;
        // Five advances leave the burst one step past its start
        a = {addrIn[18:2], m[0] ? (s[1:0] ^ 2'h1) : 2'(s[1:0] + 2'h1)};
      end
      // Pipelined read with the gate high then low
      for (int g = 1; g >= 0; g--)
      begin
        outEnable_n = g[0];
        repeat (3) step();
        readCycle = 1'b1;
        step();
        readCycle = 1'b0;
        step();
        check(dqOe_n, g[0]);
        check(dqOut, {13'h0, a, a[3:0]});
      end
      // A write in the drive cycle forces the pins released
      readCycle = 1'b1;
      step();
      readCycle = 1'b0;
      writeCycle = 1'b1;
      dqIn.data = $random(seed);
      dqIn.parity = 4'($random(seed));
      expQ.push_back({a, dqIn});
      step();
      writeCycle = 1'b0;
      check(dqOe_n, 1'b1);
      step();
      // Fill the buffer past full while the core stalls
      stall = 1'b1;
      for (int i = 0; i < 3; i++)
      begin
        dqIn.data = $random(seed);
        dqIn.parity = 4'($random(seed));
        writeCycle = 1'b1;
        if (i < 2)
          expQ.push_back({a, dqIn});
        step();
      end
      writeCycle = 1'b0;
      check(wrSpace, 1'b0);
      repeat (8)
      begin
        stall = 1'($random(seed));
        step();
      end
      stall = 1'b0;
      repeat (3) step();
      check(expQ.size(), 64'h0);
      // Test port sampling and serial output edges
      for (int t = 0; t < 2; t++)
      begin
        tdi = t[0] ? ~tdi : 1'($random(seed));
        tms = ~tdi;
        step();
        tck = 1'b1;
        repeat (4) step();
        check({tdiBit, tmsBit}, {tdi, ~tdi});
        tck = 1'b0;
        repeat (4) step();
        check(tdo, tdi);
      end
    end
    give_verdict();
  end
endmodule : ssp_data_port_tb_top
